// ### verilog/gpio_edge_io.sv
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
module gpio_edge_io #(
  parameter logic [31:0] BASE_ADDR   = 32'h0000_0000,
  parameter int unsigned TICK_CYCLES = gpio_pkg::TICK_CYCLES
) (
  input  logic                         clk,
  input  logic                         reset,
  input  logic                         hsel,
  input  logic [31:0]                  haddr,
  input  logic [1:0]                   htrans,
  input  logic                         hwrite,
  input  logic [2:0]                   hsize,
  input  logic [31:0]                  hwdata,
  input  logic                         hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  logic [gpio_pkg::NUM_CH-1:0]  pinIn,
  output gpio_pkg::pin_drive_t         pinDrive,
  output logic                         irq
);

  localparam int N  = gpio_pkg::NUM_CH;
  localparam int HW = gpio_pkg::HI_W;

  // ==========================================================================
  // Direction of each channel from nibble bits
  function automatic logic [N-1:0] dirExpand(input logic [gpio_pkg::DIR_W-1:0] dir);
    logic [N-1:0] oe;
    logic         lowDir;
    logic         highDir;
    oe = '0;
    for (int g = 0; g < gpio_pkg::NUM_GRP; g++) begin
      lowDir  = dir[2*g];
      highDir = gpio_pkg::SPLIT_GROUPS[g] ? dir[2*g+1] : dir[2*g];
      oe[g*gpio_pkg::GRP_W +: gpio_pkg::NIB_W]                    = {gpio_pkg::NIB_W{lowDir}};
      oe[g*gpio_pkg::GRP_W + gpio_pkg::NIB_W +: gpio_pkg::NIB_W]  = {gpio_pkg::NIB_W{highDir}};
    end
    return oe;
  endfunction

  // ==========================================================================
  // State
  logic [N-1:0]            latch;
  logic [N-1:0]            next_latch;
  gpio_pkg::ctrl_t         ctrl;
  gpio_pkg::ctrl_t         next_ctrl;
  logic [N-1:0]            ien;
  logic [N-1:0]            next_ien;
  logic [N-1:0]            edgeRise;
  logic [N-1:0]            next_edgeRise;
  logic [N-1:0]            stat;
  logic [N-1:0]            next_stat;
  logic                    wrPhase;
  logic                    next_wrPhase;
  logic [4:0]              wrAddr;
  logic [4:0]              next_wrAddr;
  logic [31:0]             next_hrdata;
  logic [N-1:0]            clr;
  logic [N-1:0]            syncA;
  logic [N-1:0]            syncB;
  logic [N-1:0]            filtered;
  logic [N-1:0]            prevFilt;
  logic [N-1:0]            evt;
  logic                    tick;
  logic                    accept;
  logic [4:0]              rdOff;

  // ==========================================================================
  // Pin input path
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA    <= '0;
      syncB    <= '0;
      prevFilt <= '0;
    end else begin
      syncA    <= pinIn;
      syncB    <= syncA;
      prevFilt <= filtered;
    end
  end

  tick_divider #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  input_filter #(
    .WIDTH (N),
    .SEL_W (gpio_pkg::FILT_SEL_W)
  ) u_filter (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .sel   (ctrl.filterSel),
    .din   (syncB),
    .dout  (filtered)
  );

  // Selected edge on enabled inputs only
  assign evt = ien & ((edgeRise & filtered & ~prevFilt) | (~edgeRise & ~filtered & prevFilt));

  // ==========================================================================
  // Bus slave
  assign accept    = hsel && htrans[1] && hready && (haddr[31:gpio_pkg::BLOCK_LSB] == BASE_ADDR[31:gpio_pkg::BLOCK_LSB]);
  assign rdOff     = {haddr[4:2], 2'b00};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    next_latch    = latch;
    next_ctrl     = ctrl;
    next_ien      = ien;
    next_edgeRise = edgeRise;
    clr           = '0;
    if (wrPhase) begin
      case (wrAddr)
        gpio_pkg::OFF_DATA_LO: begin
          next_latch[31:0] = hwdata;
        end
        gpio_pkg::OFF_DATA_HI: begin
          next_latch[N-1:32]  = hwdata[HW-1:0];
          next_ctrl.dir       = hwdata[gpio_pkg::DIR_LSB +: gpio_pkg::DIR_W];
          next_ctrl.filterSel = hwdata[gpio_pkg::FILT_LSB +: gpio_pkg::FILT_SEL_W];
        end
        gpio_pkg::OFF_IEN_LO: begin
          next_ien[31:0] = hwdata;
        end
        gpio_pkg::OFF_IEN_HI: begin
          next_ien[N-1:32]      = hwdata[HW-1:0];
          next_edgeRise[N-1:32] = hwdata[gpio_pkg::EDGE_HI_LSB +: HW];
        end
        gpio_pkg::OFF_EDGE_LO: begin
          next_edgeRise[31:0] = hwdata;
        end
        gpio_pkg::OFF_STAT_LO: begin
          clr[31:0] = hwdata;
        end
        gpio_pkg::OFF_STAT_HI: begin
          clr[N-1:32] = hwdata[HW-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_stat    = (stat & ~clr) | evt;
    next_wrPhase = accept && hwrite;
    next_wrAddr  = rdOff;
    next_hrdata  = 32'h0000_0000;
    if (accept && !hwrite) begin
      case (rdOff)
        gpio_pkg::OFF_DATA_LO: begin
          next_hrdata = filtered[31:0];
        end
        gpio_pkg::OFF_DATA_HI: begin
          next_hrdata = {next_ctrl.filterSel, next_ctrl.dir, filtered[N-1:32]};
        end
        gpio_pkg::OFF_IEN_LO: begin
          next_hrdata = next_ien[31:0];
        end
        gpio_pkg::OFF_IEN_HI: begin
          next_hrdata = {next_edgeRise[N-1:32], next_ien[N-1:32]};
        end
        gpio_pkg::OFF_EDGE_LO: begin
          next_hrdata = next_edgeRise[31:0];
        end
        gpio_pkg::OFF_STAT_LO: begin
          next_hrdata = next_stat[31:0];
        end
        gpio_pkg::OFF_STAT_HI: begin
          next_hrdata = {16'h0000, next_stat[N-1:32]};
        end
        default: begin
          next_hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch          <= gpio_pkg::RST_LATCH;
      ctrl.dir       <= gpio_pkg::RST_DIR;
      ctrl.filterSel <= gpio_pkg::RST_FILT;
      ien            <= gpio_pkg::RST_IEN;
      edgeRise       <= gpio_pkg::RST_EDGE;
      stat           <= '0;
      wrPhase        <= 1'b0;
      wrAddr         <= '0;
      hrdata         <= 32'h0000_0000;
    end else begin
      latch          <= next_latch;
      ctrl           <= next_ctrl;
      ien            <= next_ien;
      edgeRise       <= next_edgeRise;
      stat           <= next_stat;
      wrPhase        <= next_wrPhase;
      wrAddr         <= next_wrAddr;
      hrdata         <= next_hrdata;
    end
  end

  // ==========================================================================
  // Outputs, no inversion between bit and pin
  assign pinDrive.level = latch;
  assign pinDrive.oe    = dirExpand(ctrl.dir);
  assign irq            = |(stat & ien);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  irq_merge_a: assert property (
    ((evt & next_ien) != '0) |=> irq
  ) else $error("event did not raise the interrupt");

  flag_set_a: assert property (
    (evt != '0) |=> ((stat & $past(evt)) == $past(evt))
  ) else $error("edge event did not set its flag");

  ien_gate_a: assert property (
    1'b1 |=> ((stat & ~$past(stat) & ~$past(ien)) == '0)
  ) else $error("flag set on a disabled input");

  flag_sticky_a: assert property (
    !(wrPhase && (wrAddr == gpio_pkg::OFF_STAT_LO || wrAddr == gpio_pkg::OFF_STAT_HI))
      |=> ((stat & $past(stat)) == $past(stat))
  ) else $error("flag dropped without a clear");

  latch_drive_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_DATA_LO) |=> (pinDrive.level[31:0] == $past(hwdata))
  ) else $error("written level not on the pins");

  raw_path_a: assert property (
    (ctrl.filterSel == '0 && $stable(pinIn))[*4] |=> (filtered == $past(pinIn))
  ) else $error("unfiltered input did not follow the pin");

  block_decode_a: assert property (
    (hsel && htrans[1] && hready && haddr[31:gpio_pkg::BLOCK_LSB] != BASE_ADDR[31:gpio_pkg::BLOCK_LSB])
      |=> (!wrPhase && hrdata == 32'h0000_0000)
  ) else $error("access outside the block was taken");

  group_dir_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_DATA_HI)
      |=> (pinDrive.oe[15:8] == {8{$past(hwdata[gpio_pkg::DIR_LSB + 2])}})
  ) else $error("unsplit group direction wrong");

  rise_edge_a: assert property (
    (ien[40] && edgeRise[40] && !prevFilt[40] && filtered[40])
      |=> stat[40]
  ) else $error("rising edge on a high channel not flagged");

  fall_edge_a: assert property (
    (ien[6] && !edgeRise[6] && prevFilt[6] && !filtered[6])
      |=> stat[6]
  ) else $error("falling edge not flagged");

  clear_flag_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_STAT_LO && evt[31:0] == '0)
      |=> ((stat[31:0] & $past(hwdata)) == '0)
  ) else $error("low flag not cleared");

  clear_high_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_STAT_HI && evt[N-1:32] == '0)
      |=> ((stat[N-1:32] & $past(hwdata[HW-1:0])) == '0)
  ) else $error("high flag not cleared");

  hi_level_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_DATA_HI)
      |=> (pinDrive.level[N-1:32] == $past(hwdata[HW-1:0]))
  ) else $error("high written level not on the pins");

  split_low_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_DATA_HI)
      |=> (pinDrive.oe[19:16] == {4{$past(hwdata[gpio_pkg::DIR_LSB + 4])}})
  ) else $error("split group low nibble direction wrong");

  split_high_a: assert property (
    (wrPhase && wrAddr == gpio_pkg::OFF_DATA_HI)
      |=> (pinDrive.oe[47:44] == {4{$past(hwdata[gpio_pkg::DIR_LSB + 11])}})
  ) else $error("split group high nibble direction wrong");

  filter_hold_a: assert property (
    (ctrl.filterSel != '0 && !tick)
      |=> $stable(filtered)
  ) else $error("filtered input moved between ticks");

  read_idle_a: assert property (
    !(accept && !hwrite)
      |=> (hrdata == 32'h0000_0000)
  ) else $error("read data outside a read data phase");

  pin_read_a: assert property (
    (accept && !hwrite && rdOff == gpio_pkg::OFF_DATA_LO)
      |=> (hrdata == $past(filtered[31:0]))
  ) else $error("read data not the filtered pins");

endmodule

// ### include/gpio_pkg.sv
// Function
// - Software sets each group of eight channels to input or output, and some groups may be split into two halves of four.
// - Every one of the 48 inputs can raise an interrupt, each gated by its own enable bit.
// - Each enabled input detects either a rising or a falling edge, as software selects, and raises an event on it.
// - All interrupt events are merged onto one shared interrupt output.
// - A software-set debounce filter on every input rejects noise and chatter before reads and edge detection.
// - The registers form a block of I/O space placed on any 32-byte boundary.
// - Pins use positive logic, so register bits map onto pin levels with no inversion.
// - Each group is a plain port without handshake: writes drive pins from a latch and reads return the filtered pins.
// - A one bit means a high pin and a zero bit means a low pin, for reading and writing alike.
package gpio_pkg;

  // ==========================================================================
  // Geometry
  localparam int          NUM_CH       = 48;
  localparam int          NUM_GRP      = 6;
  localparam int          GRP_W        = 8;
  localparam int          NIB_W        = 4;
  localparam int          DIR_W        = 2 * NUM_GRP;
  localparam logic [5:0]  SPLIT_GROUPS = 6'h24;
  localparam int          FILT_SEL_W   = 4;
  localparam int          HI_W         = NUM_CH - 32;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          FILT_TICK_NS  = 1000;
  localparam int          TICK_CYCLES   = (FILT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register block
  localparam int          BLOCK_LSB    = 5;
  localparam logic [4:0]  OFF_DATA_LO  = 5'h00;
  localparam logic [4:0]  OFF_DATA_HI  = 5'h04;
  localparam logic [4:0]  OFF_IEN_LO   = 5'h08;
  localparam logic [4:0]  OFF_IEN_HI   = 5'h0c;
  localparam logic [4:0]  OFF_EDGE_LO  = 5'h10;
  localparam logic [4:0]  OFF_STAT_LO  = 5'h14;
  localparam logic [4:0]  OFF_STAT_HI  = 5'h18;
  localparam int          DIR_LSB      = 16;
  localparam int          FILT_LSB     = 28;
  localparam int          EDGE_HI_LSB  = 16;

  // ==========================================================================
  // Reset values
  localparam logic [NUM_CH-1:0]     RST_LATCH = 48'h0000_0000_0000;
  localparam logic [DIR_W-1:0]      RST_DIR   = 12'h000;
  localparam logic [FILT_SEL_W-1:0] RST_FILT  = 4'h0;
  localparam logic [NUM_CH-1:0]     RST_IEN   = 48'h0000_0000_0000;
  localparam logic [NUM_CH-1:0]     RST_EDGE  = 48'h0000_0000_0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [DIR_W-1:0]      dir;
    logic [FILT_SEL_W-1:0] filterSel;
  } ctrl_t;

  typedef struct packed {
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] oe;
  } pin_drive_t;

endpackage

// ### verilog/tick_divider.sv
`timescale 1ns/10ps
module tick_divider #(
  parameter int unsigned DIV = gpio_pkg::TICK_CYCLES
) (
  input  logic clk,
  input  logic reset,
  output logic tick
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  always_comb begin
    next_count = (count == LAST) ? '0 : count + 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tick = (count == LAST);

endmodule

// ### verilog/input_filter.sv
`timescale 1ns/10ps
module input_filter #(
  parameter int WIDTH = gpio_pkg::NUM_CH,
  parameter int SEL_W = gpio_pkg::FILT_SEL_W
) (
  input  logic             clk,
  input  logic             reset,
  input  logic             tick,
  input  logic [SEL_W-1:0] sel,
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ==========================================================================
  // Per channel: level must hold for sel ticks before it passes
  for (genvar i = 0; i < WIDTH; i++) begin : chan
    logic [SEL_W-1:0] cnt;
    logic [SEL_W-1:0] next_cnt;
    logic             level;
    logic             next_level;

    always_comb begin
      next_cnt   = cnt;
      next_level = level;
      if (sel == '0) begin
        next_level = din[i];
        next_cnt   = '0;
      end else if (din[i] == level) begin
        next_cnt = '0;
      end else if (tick) begin
        if (cnt >= sel - 1'b1) begin
          next_level = din[i];
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        cnt   <= '0;
        level <= 1'b0;
      end else begin
        cnt   <= next_cnt;
        level <= next_level;
      end
    end

    assign dout[i] = level;
  end

endmodule

// ### test/pin_world.sv
`timescale 1ns/10ps
// ==========================================================================
// Far-side TTL devices, every line pulled up
module pin_world (
  input  gpio_pkg::pin_drive_t drive,
  input  logic [47:0]          extLevel,
  input  logic [47:0]          extEn,
  output logic [47:0]          pinIn
);
  // Board drive wins; a released line floats to the pull-up
  assign pinIn = (drive.oe & drive.level) | (~drive.oe & ((extEn & extLevel) | ~extEn));
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] BASE = 32'h0000_0040;
  logic                 clk      = 1'b0;
  logic                 reset    = 1'b1;
  logic                 hsel     = 1'b0;
  logic [31:0]          haddr    = 32'h0000_0000;
  logic [1:0]           htrans   = 2'h0;
  logic                 hwrite   = 1'b0;
  logic [2:0]           hsize    = 3'h2;
  logic [31:0]          hwdata   = 32'h0000_0000;
  logic [47:0]          extLevel = 48'h0000_0000_0000;
  logic [47:0]          extEn    = 48'hffff_ffff_ffff;
  logic                 hreadyout;
  logic                 hresp;
  logic                 irq;
  logic [31:0]          hrdata;
  logic [31:0]          rd;
  logic [47:0]          pinIn;
  logic [47:0]          exp;
  gpio_pkg::pin_drive_t pinDrive;
  int                   fail_count  = 0;
  int                   check_count = 0;

  gpio_edge_io #(.BASE_ADDR(BASE), .TICK_CYCLES(2)) dut_u (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pinIn(pinIn),
    .pinDrive(pinDrive), .irq(irq));

  pin_world far_u (.drive(pinDrive), .extLevel(extLevel), .extEn(extEn), .pinIn(pinIn));

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Bus tasks
  task automatic chk(input logic [47:0] got, input logic [47:0] want, input string m);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("Error at %0t: %s got %h want %h", $time, m, got, want);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= BASE + {24'h0, off};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({47'h0, hresp}, 48'h0, "response");
    hsel <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    xfer(1'b1, off, d);
  endtask

  task automatic rdc(input logic [7:0] off, input logic [31:0] want, input string m);
    xfer(1'b0, off, 32'h0000_0000);
    chk({16'h0, rd}, {16'h0, want}, m);
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(pinDrive.oe, 48'h0, "oe after reset");
    chk({47'h0, irq}, 48'h0, "irq after reset");
    for (int i = 1; i < 8; i++) rdc(8'(4 * i), 32'h0, "word after reset");
    $display("test reset finished");

    extLevel <= 48'h5a5a_3c3c_9696;
    wr(8'h00, 32'ha5c3_0f1e);
    wr(8'h04, {4'h0, 12'h819, 16'h7e81});
    chk(pinDrive.oe, 48'hf000_000f_00ff, "direction groups");
    chk(pinDrive.level, 48'h7e81_a5c3_0f1e, "output latch");
    exp = (48'h7e81_a5c3_0f1e & 48'hf000_000f_00ff) | (48'h5a5a_3c3c_9696 & ~48'hf000_000f_00ff);
    settle();
    rdc(8'h00, exp[31:0], "pins low");
    rdc(8'h04, {4'h0, 12'h819, exp[47:32]}, "pins high");
    $display("test port finished");

    wr(8'h1c, 32'hffff_ffff);
    wr(8'h20, 32'h0000_0000);
    chk(pinDrive.level, 48'h7e81_a5c3_0f1e, "outside block write");
    rdc(8'h1c, 32'h0, "hole read");
    rdc(8'h24, 32'h0, "other block read");
    wr(8'h04, 32'h0000_0000);
    extEn <= 48'h0000_0000_00ff;
    settle();
    rdc(8'h00, 32'hffff_ff96, "released lines pulled up");
    extEn <= 48'hffff_ffff_ffff;
    $display("test decode finished");

    extLevel <= 48'h0;
    settle();
    wr(8'h08, 32'h0000_0060);
    wr(8'h10, 32'h0000_0020);
    extLevel <= 48'h0000_0000_0060;
    settle();
    chk({47'h0, irq}, 48'h1, "irq on rise");
    rdc(8'h14, 32'h0000_0020, "rising flag only");
    wr(8'h14, 32'h0000_0020);
    chk({47'h0, irq}, 48'h0, "irq after clear");
    extLevel <= 48'h0;
    settle();
    rdc(8'h14, 32'h0000_0040, "falling flag only");
    wr(8'h08, 32'h0000_0000);
    chk({47'h0, irq}, 48'h0, "masked irq");
    rdc(8'h14, 32'h0000_0040, "flag kept");
    wr(8'h14, 32'h0000_0040);
    wr(8'h0c, 32'h0100_0100);
    extLevel <= 48'h0300_0000_0000;
    settle();
    chk({47'h0, irq}, 48'h1, "irq high channel");
    rdc(8'h18, 32'h0000_0100, "high flag");
    wr(8'h18, 32'h0000_0100);
    chk({47'h0, irq}, 48'h0, "irq high cleared");
    wr(8'h0c, 32'h0000_0000);
    $display("test interrupt finished");

    extLevel <= 48'h0;
    wr(8'h04, {4'hf, 28'h0});
    repeat (80) @(posedge clk);
    wr(8'h08, 32'h0000_0001);
    wr(8'h10, 32'h0000_0001);
    extLevel <= 48'h1;
    repeat (4) @(posedge clk);
    extLevel <= 48'h0;
    repeat (80) @(posedge clk);
    rdc(8'h14, 32'h0, "glitch rejected");
    extLevel <= 48'h1;
    settle();
    rdc(8'h00, 32'h0, "filter delay");
    repeat (80) @(posedge clk);
    rdc(8'h00, 32'h1, "filtered level");
    rdc(8'h14, 32'h1, "filtered edge");
    $display("test filter finished");
    report_and_stop;
  end
endmodule
